// ==== timer_pwm_pkg.sv ====
// Purpose: Shared constants for the four-channel PWM timer block.
// Assumes: Byte-wide register port, one register per address index.
// Notes:   Channel registers repeat with a fixed stride from a base index.
package timer_pwm_pkg;
  // ==========================================================================
  // Bus geometry
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam int NCHAN = 4;

  // ==========================================================================
  // Register indices
  localparam logic [4:0] TSC_ADDR = 5'h00;
  localparam logic [4:0] CNT_HI_ADDR = 5'h01;
  localparam logic [4:0] CNT_LO_ADDR = 5'h02;
  localparam logic [4:0] MOD_HI_ADDR = 5'h03;
  localparam logic [4:0] MOD_LO_ADDR = 5'h04;
  localparam logic [4:0] CH_BASE_ADDR = 5'h05;
  localparam logic [4:0] CH_STRIDE = 5'h03;

  // ==========================================================================
  // Timer status/control fields
  localparam int TSC_FLAG_B = 7;
  localparam int TSC_IE_B = 6;
  localparam int TSC_HALT_B = 5;
  localparam int TSC_TRST_B = 4;
  localparam int TSC_PS_LSB = 0;

  // ==========================================================================
  // Channel status/control fields
  localparam int CSC_FLAG_B = 7;
  localparam int CSC_IE_B = 6;
  localparam int CSC_LINK_B = 5;
  localparam int CSC_MSA_B = 4;
  localparam int CSC_ELS_LSB = 2;
  localparam int CSC_TOV_B = 1;
  localparam int CSC_MAX_B = 0;
  localparam logic [7:0] CSC_LOWER_MASK = 8'h7f;
  localparam logic [7:0] CSC_UPPER_MASK = 8'h5f;

  // ==========================================================================
  // Encodings and reset values
  localparam logic [2:0] PS_EXT_CLK = 3'h7;
  localparam logic [1:0] ELS_TOGGLE = 2'h1;
  localparam logic [1:0] ELS_CLEAR = 2'h2;
  localparam logic [1:0] ELS_SET = 2'h3;
  localparam logic [15:0] MOD_RESET = 16'hffff;
  localparam logic [15:0] CMP_RESET = 16'h0000;
endpackage

// ==== timer_pwm_channels.sv ====
// Purpose: Four-channel 16-bit timer with PWM output, linked buffered pairs,
//          overflow and channel flags, and wait/stop/break handling.
// Assumes: One clock; external count clock is synchronised before use.
// Notes:   Pin outputs come from flops; output enables are active low.
// Functional notes
// - Period is overflow to overflow, set by modulo.
// - Toggle-on-wrap inverts pin at modulo match.
// - Pulse width spans overflow to compare match.
// - Modulo 255 undivided gives 256 clocks.
// - Compare 128 of 256 gives half duty.
// - Linked pair: lower first, upper write next.
// - At overflow, last written set becomes active.
// - Linked output on lower pin; upper pin released.
// - Pair two/three links the same way.
// - Link bit overrides low mode bit.
// - Mode 0:1 unbuffered, 1:0 buffered pair.
// - Edge/level 1:0 clears, 1:1 sets on match.
// - Toggle-on-wrap off with clear on match gives constant zero duty.
// - Full-duty bit with wrap toggle off: constant high.
// - Overflow sets flag; interrupt when enabled.
// - Channel event sets flag; interrupt when enabled.
// - Wait: keeps running, no bus, interrupt wakes.
// - Stop halts, keeps all state, then resumes.
// - Debug break freezes the counter.
// - Break without clear enable keeps flags unchanged.
// - Two-step clear survives break, finishes afterwards.
// - At modulo, flag sets and count restarts zero.
// - Prescaler divides by 1..64, code 7 external.
//
// Chosen here: strobed register access and the register offsets.
module timer_pwm_channels (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [timer_pwm_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [timer_pwm_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [timer_pwm_pkg::DATA_W-1:0] reg_rdata,
  input wire logic ext_count_clock_pin,
  input wire logic wait_mode,
  input wire logic stop_mode,
  input wire logic break_active,
  input wire logic break_clear_enable,
  output logic [timer_pwm_pkg::NCHAN-1:0] chan_out,
  output logic [timer_pwm_pkg::NCHAN-1:0] chan_oe_n,
  output logic irq_req,
  output logic wake_req
);
  import timer_pwm_pkg::*;

  // ==========================================================================
  // State
  typedef struct packed {
    logic ovf_flag;
    logic ovf_armed;
    logic ovf_irq_en;
    logic counter_halt;
    logic [2:0] prescale_select;
    logic [5:0] presc;
    logic [15:0] cnt;
    logic [15:0] modulo;
    logic mod_inhibit;
    logic [7:0] cnt_lo_latch;
    logic cnt_latched;
    logic [2:0] ext_sync;
    logic [3:0][7:0] chan_sc;
    logic [3:0][15:0] chan_cmp;
    logic [3:0] chan_armed;
    logic [3:0] chan_pin;
    logic [1:0] pair_sel;
    logic [1:0] pair_last;
    logic [7:0] rdata;
  } state_s;

  state_s q;
  state_s d;

  logic pair01_link_bit;
  logic pair23_link_bit;
  logic [3:0] released;
  logic [3:0] chan_en;
  logic run;
  logic tick;
  logic wrap;
  logic freeze;
  logic [15:0] cnt_nx;
  logic [5:0] ps_mask;
  logic ext_edge;

  // ==========================================================================
  // Channel decode
  // Link bits only exist on the lower channel of each pair.
  assign pair01_link_bit = q.chan_sc[0][CSC_LINK_B];
  assign pair23_link_bit = q.chan_sc[2][CSC_LINK_B];
  assign released = {pair23_link_bit, 1'b0, pair01_link_bit, 1'b0};

  // A channel runs compare when the link bit or the low mode bit is set, its edge/level bits are nonzero and it is not released.
  for (genvar g = 0; g < NCHAN; g++) begin : g_en
    assign chan_en[g] = (q.chan_sc[g][CSC_LINK_B] | q.chan_sc[g][CSC_MSA_B])
      & (q.chan_sc[g][CSC_ELS_LSB+:2] != 2'h0) & ~released[g];
  end

  // ==========================================================================
  // Count enable
  // Stop and break both gate the prescaler, so the prescaler and counter hold meanwhile.
  assign run = ~q.counter_halt & ~stop_mode & ~break_active;
  assign ps_mask = 6'(7'(7'h01 << q.prescale_select) - 7'h01);
  assign ext_edge = q.ext_sync[1] & ~q.ext_sync[2];
  assign tick = run & ((q.prescale_select == PS_EXT_CLK) ? ext_edge :
                       ((q.presc & ps_mask) == ps_mask));
  assign wrap = tick & (q.cnt == q.modulo);
  assign cnt_nx = (q.cnt == q.modulo) ? 16'h0000 : 16'(q.cnt + 16'h0001);
  assign freeze = break_active & ~break_clear_enable;

  // ==========================================================================
  // Next state
  // Write clears are applied first and hardware sets later, so a set wins.
  always_comb begin
    logic rd_ok;
    logic wr_ok;
    logic [15:0] cmp;
    logic [1:0] els;
    logic [4:0] base;
    int src;
    rd_ok = 1'b0;
    wr_ok = 1'b0;
    cmp = 16'h0000;
    els = 2'h0;
    base = 5'h00;
    src = 0;
    d = q;
    d.rdata = 8'h00;
    d.ext_sync = {q.ext_sync[1], q.ext_sync[0], ext_count_clock_pin};
    // The bus is cut off in wait mode; the timer itself keeps going.
    rd_ok = reg_rd & ~wait_mode;
    wr_ok = reg_wr & ~wait_mode;
    if (run) begin
      d.presc = 6'(q.presc + 6'h01);
    end
    if (tick) begin
      d.cnt = cnt_nx;
    end

    // Reads.
    if (rd_ok) begin
      case (reg_addr)
        TSC_ADDR: begin
          d.rdata = {q.ovf_flag, q.ovf_irq_en, q.counter_halt, 2'b00,
                     q.prescale_select};
          if (q.ovf_flag && !freeze) begin
            d.ovf_armed = 1'b1;
          end
        end
        CNT_HI_ADDR: begin
          // Reading the high byte holds the low byte for a coherent pair.
          d.rdata = q.cnt[15:8];
          d.cnt_lo_latch = q.cnt[7:0];
          d.cnt_latched = 1'b1;
        end
        CNT_LO_ADDR: begin
          d.rdata = q.cnt_latched ? q.cnt_lo_latch : q.cnt[7:0];
          d.cnt_latched = 1'b0;
        end
        MOD_HI_ADDR: d.rdata = q.modulo[15:8];
        MOD_LO_ADDR: d.rdata = q.modulo[7:0];
        default: d.rdata = 8'h00;
      endcase
      for (int i = 0; i < NCHAN; i++) begin
        base = 5'(CH_BASE_ADDR + CH_STRIDE * 5'(i));
        if (reg_addr == base) begin
          d.rdata = q.chan_sc[i];
          if (q.chan_sc[i][CSC_FLAG_B] && !freeze) begin
            d.chan_armed[i] = 1'b1;
          end
        end else if (reg_addr == 5'(base + 5'h01)) begin
          d.rdata = q.chan_cmp[i][15:8];
        end else if (reg_addr == 5'(base + 5'h02)) begin
          d.rdata = q.chan_cmp[i][7:0];
        end
      end
    end

    // Writes.
    if (wr_ok) begin
      case (reg_addr)
        TSC_ADDR: begin
          d.ovf_irq_en = reg_wdata[TSC_IE_B];
          d.counter_halt = reg_wdata[TSC_HALT_B];
          d.prescale_select = reg_wdata[TSC_PS_LSB+:3];
          // Frozen flags keep their arm so the second step works later.
          if (!freeze) begin
            if (!reg_wdata[TSC_FLAG_B] && q.ovf_armed) begin
              d.ovf_flag = 1'b0;
            end
            d.ovf_armed = 1'b0;
          end
          if (reg_wdata[TSC_TRST_B]) begin
            d.cnt = 16'h0000;
            d.presc = 6'h00;
          end
        end
        MOD_HI_ADDR: begin
          // Overflow flagging waits for the low byte to complete the value.
          d.modulo[15:8] = reg_wdata;
          d.mod_inhibit = 1'b1;
        end
        MOD_LO_ADDR: begin
          d.modulo[7:0] = reg_wdata;
          d.mod_inhibit = 1'b0;
        end
        default: d.mod_inhibit = q.mod_inhibit;
      endcase
      for (int i = 0; i < NCHAN; i++) begin
        base = 5'(CH_BASE_ADDR + CH_STRIDE * 5'(i));
        if (reg_addr == base) begin
          d.chan_sc[i][6:0] = reg_wdata[6:0] &
            (((i % 2) == 0) ? CSC_LOWER_MASK[6:0] : CSC_UPPER_MASK[6:0]);
          if (!freeze) begin
            if (!reg_wdata[CSC_FLAG_B] && q.chan_armed[i]) begin
              d.chan_sc[i][CSC_FLAG_B] = 1'b0;
            end
            d.chan_armed[i] = 1'b0;
          end
        end else if (reg_addr == 5'(base + 5'h01) ||
                     reg_addr == 5'(base + 5'h02)) begin
          if (reg_addr == 5'(base + 5'h01)) begin
            d.chan_cmp[i][15:8] = reg_wdata;
          end else begin
            d.chan_cmp[i][7:0] = reg_wdata;
          end
          // Remember which half of the pair software touched last.
          d.pair_last[i / 2] = (i % 2) == 1;
        end
      end
    end

    // Buffered pair source selection, swapped only at overflow.
    for (int p = 0; p < 2; p++) begin
      if (!q.chan_sc[2 * p][CSC_LINK_B]) begin
        d.pair_sel[p] = 1'b0;
      end else if (wrap) begin
        d.pair_sel[p] = q.pair_last[p];
      end
    end

    // Overflow flag; set beats any clear made above.
    if (wrap && !q.mod_inhibit) begin
      d.ovf_flag = 1'b1;
    end

    // Channel outputs: wrap toggle first, then compare on the new count,
    // so a compare of zero gives a pulse of zero width.
    for (int i = 0; i < NCHAN; i++) begin
      src = i;
      if ((i % 2) == 0 && q.chan_sc[i][CSC_LINK_B] && q.pair_sel[i / 2]) begin
        src = i + 1;
      end
      cmp = q.chan_cmp[src];
      els = q.chan_sc[i][CSC_ELS_LSB+:2];
      if (chan_en[i] && tick) begin
        if (wrap && q.chan_sc[i][CSC_TOV_B]) begin
          d.chan_pin[i] = ~q.chan_pin[i];
        end
        if (cnt_nx == cmp) begin
          d.chan_sc[i][CSC_FLAG_B] = 1'b1;
          case (els)
            ELS_TOGGLE: d.chan_pin[i] = ~d.chan_pin[i];
            ELS_CLEAR: d.chan_pin[i] = 1'b0;
            ELS_SET: d.chan_pin[i] = 1'b1;
            default: d.chan_pin[i] = d.chan_pin[i];
          endcase
        end
      end
      if (chan_en[i] && q.chan_sc[i][CSC_MAX_B] &&
          !q.chan_sc[i][CSC_TOV_B]) begin
        d.chan_pin[i] = 1'b1;
      end
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      q <= '0;
      q.counter_halt <= 1'b1;
      q.modulo <= MOD_RESET;
      q.chan_cmp <= {NCHAN{CMP_RESET}};
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // Outputs
  // A released upper pin is handed back to general I/O, never driven here.
  assign reg_rdata = q.rdata;
  assign chan_out = q.chan_pin;
  assign chan_oe_n = ~chan_en;
  always_comb begin
    irq_req = q.ovf_flag & q.ovf_irq_en;
    for (int i = 0; i < NCHAN; i++) begin
      irq_req = irq_req |
        (q.chan_sc[i][CSC_FLAG_B] & q.chan_sc[i][CSC_IE_B]);
    end
  end
  assign wake_req = wait_mode & irq_req;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_wrap_restart: assert property (wrap |=> q.cnt == 16'h0000)
    else $error("counter did not restart at modulo");
  a_count_step: assert property (tick && !wrap && !reg_wr |=>
    q.cnt == 16'($past(q.cnt) + 16'h0001))
    else $error("counter did not step by one");
  a_ovf_flag_set: assert property (wrap && !q.mod_inhibit |=> q.ovf_flag)
    else $error("overflow flag missed");
  a_freeze_count: assert property ((stop_mode || break_active) && !reg_wr
    |=> $stable(q.cnt))
    else $error("counter moved while frozen");
  a_break_keep: assert property (freeze && q.ovf_flag |=> q.ovf_flag)
    else $error("flag changed in protected break");
  a_zero_duty: assert property (chan_en[0] && !q.chan_sc[0][CSC_TOV_B] &&
    !q.chan_sc[0][CSC_MAX_B] &&
    q.chan_sc[0][CSC_ELS_LSB+:2] == ELS_CLEAR && !chan_out[0] |=>
    !chan_out[0])
    else $error("zero duty output went high");
  a_full_duty: assert property (chan_en[0] && q.chan_sc[0][CSC_MAX_B] &&
    !q.chan_sc[0][CSC_TOV_B] |=> chan_out[0])
    else $error("full duty output went low");
  a_link_release: assert property (pair01_link_bit |-> chan_oe_n[1])
    else $error("upper pin driven while linked");
  a_link_switch: assert property (pair01_link_bit && wrap && q.pair_last[0]
    |=> q.pair_sel[0])
    else $error("pair source not switched at overflow");
  a_irq_wake: assert property (wait_mode && q.ovf_flag && q.ovf_irq_en
    |-> irq_req && wake_req)
    else $error("enabled overflow did not wake");
  a_chan_irq: assert property (q.chan_sc[2][CSC_FLAG_B] &&
    q.chan_sc[2][CSC_IE_B] |-> irq_req)
    else $error("channel interrupt not raised");

  // A read in wait mode must return nothing, since the bus is cut off.
  a_wait_no_read: assert property (wait_mode && reg_rd |=>
    reg_rdata == 8'h00)
    else $error("read answered in wait mode");
  // Stop keeps the period setting and the prescaler phase as they were.
  a_stop_keep: assert property (stop_mode && !reg_wr |=>
    $stable(q.modulo) && $stable(q.presc))
    else $error("state moved in stop");
  // Divide by two must never tick on two cycles in a row.
  a_ps_div_two: assert property (tick && !reg_wr &&
    q.prescale_select == 3'h1 |=> !tick)
    else $error("prescaler ticked on consecutive cycles");
  // A half-written modulo must not raise the overflow flag on its own.
  a_mod_inhibit: assert property (wrap && q.mod_inhibit &&
    !q.ovf_flag |=> !q.ovf_flag)
    else $error("overflow flagged while modulo half written");
  // A compare on an unlinked channel always raises its flag.
  a_chan_flag_set: assert property (chan_en[0] && tick &&
    !q.chan_sc[0][CSC_LINK_B] && cnt_nx == q.chan_cmp[0]
    |=> q.chan_sc[0][CSC_FLAG_B])
    else $error("channel flag missed on compare");
  // The upper pin of the second pair is released while it is linked.
  a_pair23_release: assert property (pair23_link_bit |->
    chan_oe_n[3])
    else $error("upper pin of second pair driven while linked");
  // With no output action chosen the channel leaves its pin alone.
  a_idle_release: assert property (
    q.chan_sc[1][CSC_ELS_LSB+:2] == 2'h0 |-> chan_oe_n[1])
    else $error("pin driven with no output action");

  c_overflow: cover property (wrap ##1 q.ovf_flag);
  c_pair_swap: cover property (pair01_link_bit && wrap && q.pair_last[0]);
  c_compare: cover property (chan_en[0] && tick && cnt_nx == q.chan_cmp[0]);
  c_ext_tick: cover property (q.prescale_select == PS_EXT_CLK && tick);
  c_full_duty: cover property (chan_en[0] && q.chan_sc[0][CSC_MAX_B] &&
    chan_out[0]);
endmodule

// ==== pwm_load.sv ====
// Purpose: Load on the four channel pins; measures pulse and period.
// Assumes: Each pin has a board pull-up that wins when the block lets go.
// Notes:   Widths are counted in ref_clk cycles between pin edges.
module pwm_load (
  input wire logic ref_clk,
  input wire logic [3:0] chan_out,
  input wire logic [3:0] chan_oe_n,
  output logic [3:0] pin_lvl,
  output logic [3:0][15:0] hi_len,
  output logic [3:0][15:0] per_len
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] prev_q = '0;
  logic [3:0][15:0] hi_cnt_q = '0;
  logic [3:0][15:0] per_cnt_q = '0;
  // ==========================================================================
  // Pin level
  // A released pin goes to the pull-up level, never the last driven value.
  assign pin_lvl = (~chan_oe_n & chan_out) | chan_oe_n;
  // Rise to rise is the period, rise to fall the high time.
  always @(posedge ref_clk) begin
    for (int i = 0; i < 4; i++) begin
      if (pin_lvl[i] && !prev_q[i]) begin
        per_len[i] <= per_cnt_q[i];
        per_cnt_q[i] <= 16'h0001;
        hi_cnt_q[i] <= 16'h0001;
      end else begin
        per_cnt_q[i] <= per_cnt_q[i] + 16'h0001;
        if (pin_lvl[i]) hi_cnt_q[i] <= hi_cnt_q[i] + 16'h0001;
      end
      if (!pin_lvl[i] && prev_q[i]) hi_len[i] <= hi_cnt_q[i];
    end
    prev_q <= pin_lvl;
  end
endmodule

// ==== tb_top.sv ====
// Purpose: Self-checking bench for the four-channel PWM timer.
// Assumes: 50 MHz ref_clk, synchronous active-low reset, byte register port.
// Notes:   The external count clock runs at a quarter of ref_clk in code 7.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import timer_pwm_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic wait_mode = 1'b0;
  logic stop_mode = 1'b0;
  logic break_active = 1'b0;
  logic break_clear_enable = 1'b0;
  logic ext_clk = 1'b0;
  logic [7:0] reg_rdata;
  logic [3:0] chan_out, chan_oe_n, pin_lvl;
  logic irq_req, wake_req;
  logic [3:0][15:0] hi_len, per_len;
  int n_fail = 0;
  int n_compared = 0;
  // ==========================================================================
  // Clock, design and load
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  timer_pwm_channels dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_count_clock_pin(ext_clk),
    .wait_mode(wait_mode), .stop_mode(stop_mode),
    .break_active(break_active), .break_clear_enable(break_clear_enable),
    .chan_out(chan_out), .chan_oe_n(chan_oe_n), .irq_req(irq_req),
    .wake_req(wake_req));
  pwm_load load (.ref_clk(ref_clk), .chan_out(chan_out),
    .chan_oe_n(chan_oe_n), .pin_lvl(pin_lvl), .hi_len(hi_len),
    .per_len(per_len));
  // ==========================================================================
  // Shared tasks
  // Every check counts itself and reports a mismatch at once.
  task automatic chk(input string what, input logic [15:0] e,
                     input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample mid-cycle.
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
    // Return on a rising edge so callers drive inputs right after it.
    @(posedge ref_clk);
  endtask
  task automatic rd_cnt(output logic [15:0] c);
    rd(CNT_HI_ADDR, c[15:8]);
    rd(CNT_LO_ADDR, c[7:0]);
  endtask
  function automatic logic [4:0] ca(input int ch);
    return CH_BASE_ADDR + CH_STRIDE * 5'(ch);
  endfunction
  task automatic wr_cmp(input int ch, input logic [15:0] v);
    wr(ca(ch) + 5'h01, v[15:8]);
    wr(ca(ch) + 5'h02, v[7:0]);
  endtask
  // Halt and clear first, then period, width, mode, then release the halt.
  task automatic cfg(input int ch, input logic [7:0] csc,
                     input logic [15:0] cmp, input logic [2:0] ps);
    wr(TSC_ADDR, 8'h30 | 8'(ps));
    wr(MOD_HI_ADDR, 8'h00);
    wr(MOD_LO_ADDR, 8'hff);
    wr_cmp(ch, cmp);
    wr(ca(ch), csc);
    wr(TSC_ADDR, 8'(ps));
  endtask
  task automatic hold_chk(input int ch, input logic v);
    int bad;
    bad = 0;
    repeat (300) begin
      @(negedge ref_clk);
      if (pin_lvl[ch] !== v) bad++;
    end
    chk("steady pin", 16'h0000, 16'(bad));
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    logic [7:0] d;
    rd(TSC_ADDR, d);
    chk("status after reset", 16'h0020, {8'h00, d});
    rd(MOD_HI_ADDR, d);
    chk("modulo high", 16'h00ff, {8'h00, d});
    rd(5'h1f, d);
    chk("unmapped read", 16'h0000, {8'h00, d});
    chk("pins released", 16'h000f, {12'h000, chan_oe_n});
  endtask
  task automatic t_pwm(input logic [2:0] ps, input logic [7:0] csc,
                       input logic [15:0] cmp, input logic [15:0] hi);
    logic [7:0] d;
    cfg(0, csc, cmp, ps);
    repeat (3 * (256 << ps) + 20) @(posedge ref_clk);
    chk("period", 16'd256 << ps, per_len[0]);
    chk("high time", hi, hi_len[0]);
    rd(ca(0), d);
    chk("channel flag", 16'h0001, {15'h0000, d[7]});
    rd(TSC_ADDR, d);
    chk("overflow flag", 16'h0001, {15'h0000, d[7]});
  endtask
  // The external clock runs at a quarter of ref_clk, so a count is four.
  task automatic t_ext;
    cfg(0, 8'h1a, 16'h0080, PS_EXT_CLK);
    repeat (3 * 256 + 8) begin
      repeat (2) @(posedge ref_clk);
      ext_clk <= 1'b1;
      repeat (2) @(posedge ref_clk);
      ext_clk <= 1'b0;
    end
    chk("external period", 16'd1024, per_len[0]);
    chk("external high", 16'd512, hi_len[0]);
  endtask
  task automatic t_const;
    cfg(0, 8'h18, 16'h0080, 3'h0);
    repeat (300) @(posedge ref_clk);
    hold_chk(0, 1'b0);
    wr(ca(0), 8'h19);
    repeat (5) @(posedge ref_clk);
    hold_chk(0, 1'b1);
  endtask
  task automatic t_pair(input int lo);
    cfg(lo, 8'h3a, 16'h0040, 3'h0);
    repeat (800) @(posedge ref_clk);
    chk("lower set rules", 16'd64, hi_len[lo]);
    chk("upper released", 16'h0001, {15'h0000, chan_oe_n[lo + 1]});
    wr_cmp(lo + 1, 16'h0020);
    repeat (800) @(posedge ref_clk);
    chk("upper set rules", 16'd32, hi_len[lo]);
    wr_cmp(lo, 16'h0060);
    repeat (800) @(posedge ref_clk);
    chk("last written rules", 16'd96, hi_len[lo]);
  endtask
  // Frozen counts must read the same twice; flags survive a protected break.
  task automatic t_modes;
    logic [7:0] d;
    logic [15:0] c1, c2;
    wr(TSC_ADDR, 8'h40);
    repeat (300) @(posedge ref_clk);
    chk("irq request", 16'h0001, {15'h0000, irq_req});
    wait_mode <= 1'b1;
    rd(TSC_ADDR, d);
    chk("read in wait", 16'h0000, {8'h00, d});
    chk("wake request", 16'h0001, {15'h0000, wake_req});
    wait_mode <= 1'b0;
    stop_mode <= 1'b1;
    rd_cnt(c1);
    repeat (40) @(posedge ref_clk);
    rd_cnt(c2);
    chk("count in stop", c1, c2);
    stop_mode <= 1'b0;
    rd_cnt(c2);
    chk("count resumes", 16'h0001, {15'h0000, c2 != c1});
    rd(TSC_ADDR, d);
    break_active <= 1'b1;
    rd_cnt(c1);
    repeat (40) @(posedge ref_clk);
    rd_cnt(c2);
    chk("count in break", c1, c2);
    wr(TSC_ADDR, 8'h60);
    rd(TSC_ADDR, d);
    chk("flag kept in break", 16'h0001, {15'h0000, d[7]});
    break_active <= 1'b0;
    wr(TSC_ADDR, 8'h60);
    rd(TSC_ADDR, d);
    chk("second step clears", 16'h0060, {8'h00, d});
    // With clearing allowed, a clear in break must outlast the break.
    wr(TSC_ADDR, 8'h40);
    repeat (300) @(posedge ref_clk);
    rd(TSC_ADDR, d);
    break_clear_enable <= 1'b1;
    break_active <= 1'b1;
    wr(TSC_ADDR, 8'h60);
    rd(TSC_ADDR, d);
    chk("clear in break", 16'h0060, {8'h00, d});
    break_active <= 1'b0;
    break_clear_enable <= 1'b0;
    rd(TSC_ADDR, d);
    chk("clear kept after break", 16'h0060, {8'h00, d});
  endtask
  // ==========================================================================
  // Verdict
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // The tests need about 12800 cycles, so this limit is generous.
  initial begin
    repeat (40000) @(posedge ref_clk);
    n_fail++;
    $display("unexpected run length: expected end seen timeout");
    end_sim();
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    t_pwm(3'h0, 8'h1a, 16'h0080, 16'd128);
    t_pwm(3'h1, 8'h1a, 16'h0080, 16'd256);
    t_pwm(3'h0, 8'h1e, 16'h0040, 16'd192);
    t_ext();
    t_const();
    t_pair(0);
    t_pair(2);
    t_modes();
    end_sim();
  end
endmodule
